//--- logic/psrp_host.sv
// host controller driving an asynchronous pseudo static ram
`timescale 1ns/1ps
// Functional notes
// RQ1: address 2M words of 16 bits with a 21-bit word address.
// RQ2: page burst reads 8 words, only low three address bits change.
// RQ3: write strobe low writes; strobe high, output enable low reads.
// RQ4: lane strobes low select bytes 7:0 and 15:8.
// RQ5: enable high, select high is standby; select low is power-down.
// RQ6: power-down: select low 10 ms, then wait 300 us before access.
// RQ7: keep select stable 30 us after power-up before any access.
// RQ8: read data valid by 75 ns; read cycle 75 ns to 10000 ns.
// RQ9: page step at least 30 ns, whole burst within 10000 ns.
// RQ10: write pulse 50 ns, address lead 60 ns, cycle at most 10000 ns.
// RQ11: chip enable high at least 10 ns between accesses.
// RQ12: write strobe high at least 15 ns between write pulses.
// RQ13: short read address cycles need a full read cycle every 10 us.
// RQ14: short write cycles need a full write cycle every 10 us.
// RQ15: device releases data within 20 ns after write strobe falls.
// RQ16: output enable high in a write keeps device outputs off.
// RQ17: enable or lane falling at or after strobe fall keeps outputs off.
// RQ18: enable or lane rising at or before strobe rise keeps outputs off.
// RQ19: never drive data bus while the device drives it.
// RQ20: all timing from clock counters, minimums up, maximums down.
// RQ21: after power-down treat memory contents as undefined.
module psrp_host
  import psrp_pkg::*;
#(
  parameter int          AW         = ADDR_W,
  parameter int          DW         = DATA_W,
  parameter longint      SLEEP_CYC  = SLEEP_CYC_L,
  parameter longint      WAKE_CYC   = WAKE_CYC_L,
  parameter longint      PWRUP_CYC  = PWRUP_CYC_L
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           srst,
  // user request side
  input  wire logic           reqValid,
  input  wire psrp_req_t      req,
  output      logic           reqReady,
  output      logic           rspValid,
  output      logic [DW-1:0]  rspData,
  output      logic           contentLost,
  // memory pins
  output      logic [AW-1:0]  wordAddress,
  output      psrp_pins_t     memPins,
  input  wire logic [DW-1:0]  dataBusIn,
  output      logic [DW-1:0]  dataBusOut,
  output      logic           dataBusOe
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  psrp_state_t          state_r,   state_nxt;
  logic [CNT_W-1:0]     cnt_r,     cnt_nxt;
  logic [CNT_W-1:0]     burst_r,   burst_nxt;
  logic [PAGE_BITS-1:0] step_r,    step_nxt;
  logic [AW-1:0]        addr_r,    addr_nxt;
  logic [DW-1:0]        dout_r,    dout_nxt;
  logic                 oe_r,      oe_nxt;
  psrp_pins_t           pins_r,    pins_nxt;
  logic [1:0]           lane_r,    lane_nxt;
  logic                 rdy_r,     rdy_nxt;
  logic                 rv_r,      rv_nxt;
  logic [DW-1:0]        rd_r,      rd_nxt;
  logic                 lost_r,    lost_nxt;
  logic [DW-1:0]        dSync1_r,  dSync2_r;

  // byte lane mask for reads: unselected lane reads as zero
  function automatic logic [DW-1:0] laneMask(input logic [1:0] en);
    laneMask = {{(DW/2){en[1]}}, {(DW/2){en[0]}}};
  endfunction

  // ----------------------------------------------------------------------
  // data input synchroniser
  // ----------------------------------------------------------------------
  // read data comes from an async pin, so two flops before any use
  always_ff @(posedge clk) begin
    dSync1_r <= dataBusIn;
    dSync2_r <= dSync1_r;
  end

  // ----------------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------------
  // reads and writes run a full cycle, and a page burst opens with a full read
  // and ends within MAX_CYC, so its short page steps always follow a full cycle
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 1'b1;
    burst_nxt = burst_r + 1'b1;
    step_nxt  = step_r;
    addr_nxt  = addr_r;
    dout_nxt  = dout_r;
    oe_nxt    = oe_r;
    pins_nxt  = pins_r;
    lane_nxt  = lane_r;
    rdy_nxt   = 1'b0;
    rv_nxt    = 1'b0;
    rd_nxt    = rd_r;
    lost_nxt  = lost_r;
    case (state_r)
      PSRP_ST_PWRUP: begin
        pins_nxt = PINS_IDLE;                          // RQ7
        if (cnt_r >= CNT_W'(PWRUP_CYC - 1)) begin      // RQ7 RQ20
          state_nxt = PSRP_ST_IDLE;
          rdy_nxt   = 1'b1;
        end
      end
      PSRP_ST_IDLE: begin
        rdy_nxt = 1'b1;
        cnt_nxt = '0;
        burst_nxt = '0;
        if (reqValid && rdy_r) begin
          rdy_nxt  = 1'b0;
          addr_nxt = req.addr;                         // RQ1
          lane_nxt = req.laneEn;
          step_nxt = '0;
          pins_nxt.lowerLaneStrobeN = ~req.laneEn[0];  // RQ4
          pins_nxt.upperLaneStrobeN = ~req.laneEn[1];  // RQ4
          case (req.cmd)
            PSRP_CMD_WRITE: begin
              // enable, lane and strobe fall together; oe stays high
              state_nxt = PSRP_ST_WRITE;
              pins_nxt.chipEnableN   = 1'b0;
              pins_nxt.writeStrobeN  = 1'b0;           // RQ3 RQ17
              pins_nxt.outputEnableN = 1'b1;           // RQ16
              dout_nxt  = req.wdata;
              oe_nxt    = 1'b1;                        // RQ19
            end
            PSRP_CMD_SLEEP: begin
              state_nxt = PSRP_ST_SLEEP;
              pins_nxt  = PINS_OFF;                    // RQ5 RQ6
              lost_nxt  = 1'b1;                        // RQ21
            end
            PSRP_CMD_PAGE: begin
              state_nxt = PSRP_ST_PAGE;
              addr_nxt  = {req.addr[AW-1:PAGE_BITS],
                           {PAGE_BITS{1'b0}}};         // RQ2
              pins_nxt.chipEnableN   = 1'b0;
              pins_nxt.outputEnableN = 1'b0;
            end
            default: begin
              state_nxt = PSRP_ST_READ;
              pins_nxt.chipEnableN   = 1'b0;           // RQ3
              pins_nxt.outputEnableN = 1'b0;
            end
          endcase
        end
      end
      PSRP_ST_READ: begin
        // sample two flops late; hold cycle open for sync latency
        if (cnt_r >= CNT_W'(READ_CYC + 1)) begin       // RQ8 RQ13 RQ20
          rd_nxt    = dSync2_r & laneMask(lane_r);
          rv_nxt    = 1'b1;
          state_nxt = PSRP_ST_GAP;
          pins_nxt  = PINS_IDLE;
          cnt_nxt   = '0;
        end
      end
      PSRP_ST_PAGE: begin
        // first word needs full access, later ones a page step
        if ((step_r == '0 && cnt_r >= CNT_W'(READ_CYC + 1)) ||
            (step_r != '0 && cnt_r >= CNT_W'(PAGE_CYC + 1))) begin // RQ9
          rd_nxt  = dSync2_r & laneMask(lane_r);
          rv_nxt  = 1'b1;
          cnt_nxt = '0;
          if (step_r == 3'(PAGE_WORDS - 1) ||
              burst_r >= CNT_W'(MAX_CYC - PAGE_CYC - 2)) begin // RQ9
            state_nxt = PSRP_ST_GAP;
            pins_nxt  = PINS_IDLE;
          end else begin
            step_nxt = step_r + 1'b1;
            addr_nxt = {addr_r[AW-1:PAGE_BITS], step_r + 3'h1}; // RQ2
          end
        end
      end
      PSRP_ST_WRITE: begin
        // strobe and enable rise together, address held throughout
        if (cnt_r >= CNT_W'(WR_CYC - 1)) begin         // RQ10 RQ14 RQ20
          state_nxt = PSRP_ST_GAP;
          pins_nxt  = PINS_IDLE;                       // RQ18
          cnt_nxt   = '0;
        end
      end
      PSRP_ST_GAP: begin
        oe_nxt = 1'b0;
        if (cnt_r >= CNT_W'(GAP_CYC - 1)) begin        // RQ11 RQ12
          state_nxt = PSRP_ST_IDLE;
          rdy_nxt   = 1'b1;
          cnt_nxt   = '0;
        end
      end
      PSRP_ST_SLEEP: begin
        if (cnt_r >= CNT_W'(SLEEP_CYC - 1)) begin      // RQ6 RQ20
          state_nxt = PSRP_ST_WAKE;
          pins_nxt  = PINS_IDLE;
          cnt_nxt   = '0;
        end
      end
      PSRP_ST_WAKE: begin
        if (cnt_r >= CNT_W'(WAKE_CYC - 1)) begin       // RQ6
          state_nxt = PSRP_ST_IDLE;
          rdy_nxt   = 1'b1;
          cnt_nxt   = '0;
        end
      end
      default: begin
        state_nxt = PSRP_ST_PWRUP;
        pins_nxt  = PINS_IDLE;
      end
    endcase
    // a fresh write after power-down means software is reinitialising
    if (state_r == PSRP_ST_IDLE && reqValid && rdy_r &&
        req.cmd == PSRP_CMD_WRITE)
      lost_nxt = 1'b0;                                 // RQ21
  end

  // ----------------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= PSRP_ST_PWRUP;
      cnt_r   <= '0;
      burst_r <= '0;
      step_r  <= '0;
      addr_r  <= ADDR_RST;
      dout_r  <= DATA_RST;
      oe_r    <= 1'b0;
      pins_r  <= PINS_IDLE;
      lane_r  <= '0;
      rdy_r   <= 1'b0;
      rv_r    <= 1'b0;
      rd_r    <= DATA_RST;
      lost_r  <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      burst_r <= burst_nxt;
      step_r  <= step_nxt;
      addr_r  <= addr_nxt;
      dout_r  <= dout_nxt;
      oe_r    <= oe_nxt;
      pins_r  <= pins_nxt;
      lane_r  <= lane_nxt;
      rdy_r   <= rdy_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      lost_r  <= lost_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reqReady    = rdy_r;
  assign rspValid    = rv_r;
  assign rspData     = rd_r;
  assign contentLost = lost_r;
  assign wordAddress = addr_r;
  assign memPins     = pins_r;
  assign dataBusOut  = dout_r;
  assign dataBusOe   = oe_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_no_contention;
    @(posedge clk) disable iff (srst)
      dataBusOe |-> memPins.outputEnableN;
  endproperty
  a_no_contention: assert property (p_no_contention) // RQ19
    else $error("bus driven while memory output enabled");

  property p_write_pulse;
    @(posedge clk) disable iff (srst)
      $fell(memPins.writeStrobeN) |-> !memPins.writeStrobeN [*2];
  endproperty
  a_write_pulse: assert property (p_write_pulse) // RQ10
    else $error("write pulse shorter than minimum");

  property p_enable_gap;
    @(posedge clk) disable iff (srst)
      $rose(memPins.chipEnableN) |-> memPins.chipEnableN [*2];
  endproperty
  a_enable_gap: assert property (p_enable_gap) // RQ11
    else $error("chip enable gap too short");

  property p_strobe_gap;
    @(posedge clk) disable iff (srst)
      $rose(memPins.writeStrobeN) |-> memPins.writeStrobeN [*1] ##1
        memPins.writeStrobeN;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) // RQ12
    else $error("write strobe gap too short");

  property p_read_len;
    @(posedge clk) disable iff (srst)
      (state_r == PSRP_ST_IDLE && state_nxt == PSRP_ST_READ) |=>
        !memPins.chipEnableN [*4];
  endproperty
  a_read_len: assert property (p_read_len) // RQ8
    else $error("read cycle shorter than minimum");

  property p_write_oe_high;
    @(posedge clk) disable iff (srst)
      !memPins.writeStrobeN |-> memPins.outputEnableN;
  endproperty
  a_write_oe_high: assert property (p_write_oe_high) // RQ16
    else $error("output enable low during write");

  property p_page_upper;
    @(posedge clk) disable iff (srst)
      (state_r == PSRP_ST_PAGE && $past(state_r) == PSRP_ST_PAGE) |->
        wordAddress[AW-1:PAGE_BITS] == $past(wordAddress[AW-1:PAGE_BITS]);
  endproperty
  a_page_upper: assert property (p_page_upper) // RQ2
    else $error("upper address changed within page");

  property p_sleep_lost;
    @(posedge clk) disable iff (srst)
      (state_r == PSRP_ST_SLEEP) |-> (contentLost && !memPins.powerSelect);
  endproperty
  a_sleep_lost: assert property (p_sleep_lost) // RQ6
    else $error("power-down without select low or lost flag");
endmodule // psrp_host

//--- logic/psrp_pkg.sv
// package: constants and carrier types for the pseudo static ram host port
package psrp_pkg;
  // ----------------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W      = 21;
  localparam int DATA_W      = 16;
  localparam int PAGE_WORDS  = 8;
  localparam int PAGE_BITS   = 3;
  // ----------------------------------------------------------------------
  // timing, figures as printed
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS        = 40000;
  localparam int READ_CYCLE_NS        = 75;
  localparam int CYCLE_MAX_NS         = 10000;
  localparam int PAGE_STEP_NS         = 30;
  localparam int WRITE_PULSE_NS       = 50;
  localparam int ADDRESS_LEAD_NS      = 60;
  localparam int ENABLE_GAP_NS        = 10;
  localparam int STROBE_GAP_NS        = 15;
  localparam int SLEEP_PULSE_MS       = 10;
  localparam int WAKE_HOLD_US         = 300;
  localparam int POWERUP_HOLD_US      = 30;
  // ----------------------------------------------------------------------
  // derived cycle counts (minimums round up, maximums round down)
  // ----------------------------------------------------------------------
  localparam int READ_CYC   = (READ_CYCLE_NS*1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam int MAX_CYC    = (CYCLE_MAX_NS*1000) / CLK_PERIOD_PS;
  localparam int PAGE_CYC   = (PAGE_STEP_NS*1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam int WPULSE_CYC = (WRITE_PULSE_NS*1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam int ALEAD_CYC  = (ADDRESS_LEAD_NS*1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam int WR_CYC     = (WPULSE_CYC > ALEAD_CYC) ? WPULSE_CYC
                              : ALEAD_CYC;
  localparam int CEGAP_CYC  = (ENABLE_GAP_NS*1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam int WEGAP_CYC  = (STROBE_GAP_NS*1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam int GAP_CYC    = (CEGAP_CYC > WEGAP_CYC) ? CEGAP_CYC
                              : WEGAP_CYC;
  localparam longint SLEEP_CYC_L = (64'(SLEEP_PULSE_MS)*1000000000
                              + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint WAKE_CYC_L  = (64'(WAKE_HOLD_US)*1000000
                              + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint PWRUP_CYC_L = (64'(POWERUP_HOLD_US)*1000000
                              + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 24;
  // ----------------------------------------------------------------------
  // reset values of pin outputs
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  // ----------------------------------------------------------------------
  // commands and states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PSRP_CMD_READ  = 2'b00,
    PSRP_CMD_WRITE = 2'b01,
    PSRP_CMD_PAGE  = 2'b10,
    PSRP_CMD_SLEEP = 2'b11
  } psrp_cmd_t;

  typedef enum logic [2:0] {
    PSRP_ST_PWRUP = 3'b000,
    PSRP_ST_IDLE  = 3'b001,
    PSRP_ST_READ  = 3'b010,
    PSRP_ST_PAGE  = 3'b011,
    PSRP_ST_WRITE = 3'b100,
    PSRP_ST_GAP   = 3'b101,
    PSRP_ST_SLEEP = 3'b110,
    PSRP_ST_WAKE  = 3'b111
  } psrp_state_t;

  // user request
  typedef struct packed {
    psrp_cmd_t         cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        laneEn;   // bit0 lower, bit1 upper
  } psrp_req_t;

  // control pins toward the memory
  typedef struct packed {
    logic chipEnableN;
    logic powerSelect;
    logic outputEnableN;
    logic writeStrobeN;
    logic lowerLaneStrobeN;
    logic upperLaneStrobeN;
  } psrp_pins_t;

  localparam psrp_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam psrp_pins_t PINS_OFF  = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : psrp_pkg

//--- tb/psrp_mem_model.sv
// behavioural model of the pseudo static ram facing the host port
`timescale 1ns/1ps
module psrp_mem_model
  import psrp_pkg::*;
#(
  parameter int ACC_NS = 25
) (
  // pins from the host
  input  wire logic [ADDR_W-1:0] wordAddress,
  input  wire psrp_pins_t        memPins,
  input  wire logic [DATA_W-1:0] dataBusOut,
  input  wire logic              dataBusOe,
  // resolved bus and contention flag
  output      logic [DATA_W-1:0] dataBusIn,
  output      logic              busClash
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] junk = 16'h5a3c;
  logic [DATA_W-1:0] rdWord;
  logic [DATA_W-1:0] rdLate;
  logic [DATA_W-1:0] old;
  logic [DATA_W-1:0] wData;
  logic [ADDR_W-1:0] wAddr;
  logic [1:0]        wLane;
  logic [1:0]        laneOn;
  logic              pend = 1'b0;
  logic              selected;

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // released lines never keep the last value, so a stale sample shows
  always #20 junk = ~{junk[14:0], junk[15]};
  assign selected = !memPins.chipEnableN && memPins.powerSelect;
  // strobe low or oe high takes every lane off
  assign #(ACC_NS) laneOn = {2{selected && !memPins.outputEnableN
    && memPins.writeStrobeN}} & ~{memPins.upperLaneStrobeN,
    memPins.lowerLaneStrobeN};
  // any address, page steps included, settles after the access time
  always @* rdWord = mem.exists(wordAddress) ? mem[wordAddress] : junk;
  assign #(ACC_NS) rdLate = rdWord;
  always @* begin
    for (int b = 0; b < DATA_W; b++) begin
      dataBusIn[b] = dataBusOe ? dataBusOut[b]
        : (laneOn[b/8] ? rdLate[b] : junk[b]);
    end
  end
  assign busClash = dataBusOe && (|laneOn);

  // ----------------------------------------------------------------------
  // write path and power-down
  // ----------------------------------------------------------------------
  // pins rise on one edge, so the write is captured while still live
  always @* begin
    if (selected && !memPins.writeStrobeN) begin
      wAddr = wordAddress;
      wData = dataBusIn;
      wLane = ~{memPins.upperLaneStrobeN, memPins.lowerLaneStrobeN};
      pend  = 1'b1;
    end
  end
  // unselected lane keeps its old byte
  always @(posedge memPins.writeStrobeN) begin
    if (pend) begin
      old = mem.exists(wAddr) ? mem[wAddr] : 16'h0000;
      mem[wAddr] = (old & ~{{8{wLane[1]}}, {8{wLane[0]}}})
        | (wData & {{8{wLane[1]}}, {8{wLane[0]}}});
      pend = 1'b0;
    end
  end
  always @(negedge memPins.powerSelect) mem.delete();
endmodule // psrp_mem_model

//--- tb/tb_top.sv
// self-checking bench for the pseudo static ram host port
`timescale 1ns/1ps
module tb_top;
  import psrp_pkg::*;
  localparam int TMO = 20000;
  localparam int SLP = 8;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              reqValid = 1'b0;
  psrp_req_t         req = '0;
  logic              reqReady, rspValid, contentLost, dataBusOe, busClash;
  logic [DATA_W-1:0] rspData, dataBusIn, dataBusOut, d;
  logic [ADDR_W-1:0] wordAddress, a;
  logic [1:0]        l;
  psrp_pins_t        memPins;
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int ceLow = 0, ceHigh = 0, weLow = 0, weHigh = 0, selLow = 0;
  int selHigh = 0, aHold = 0;
  logic              wasRead = 1'b0;
  logic [ADDR_W-1:0] aPrev = '0;

  psrp_host #(.SLEEP_CYC(SLP), .WAKE_CYC(SLP), .PWRUP_CYC(SLP)) psrp_host_i (
    .clk(clk), .srst(srst), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .contentLost(contentLost), .wordAddress(wordAddress),
    .memPins(memPins), .dataBusIn(dataBusIn), .dataBusOut(dataBusOut),
    .dataBusOe(dataBusOe));
  psrp_mem_model psrp_mem_model_i (
    .wordAddress(wordAddress), .memPins(memPins), .dataBusOut(dataBusOut),
    .dataBusOe(dataBusOe), .dataBusIn(dataBusIn), .busClash(busClash));

  always #20 clk = ~clk;

  // ----------------------------------------------------------------------
  // comparison and closing
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic c);
    check({15'h0, c}, 16'h0001);
  endtask
  task automatic end_of_test();
    $display("counts: mismatches %0d comparisons %0d", n_mismatch,
             comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // request tasks; expectations come from the shadow copy
  // ----------------------------------------------------------------------
  function automatic logic [15:0] lmask(input logic [1:0] m);
    return {{8{m[1]}}, {8{m[0]}}};
  endfunction
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (reqReady !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk1(reqReady === 1'b1);
  endtask
  task automatic send(input psrp_cmd_t c, input logic [20:0] ad,
                      input logic [15:0] dd, input logic [1:0] ll);
    wait_ready();
    reqValid <= 1'b1;
    req      <= '{c, ad, dd, ll};
    @(posedge clk);
    reqValid <= 1'b0;
  endtask
  task automatic expect_word(input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    while (rspValid !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk1(rspValid === 1'b1);
    check(rspData, exp);
  endtask
  task automatic wr(input logic [20:0] ad, input logic [15:0] dd,
                    input logic [1:0] ll);
    logic [15:0] o;
    o = shadow.exists(ad) ? shadow[ad] : 16'h0000;
    shadow[ad] = (o & ~lmask(ll)) | (dd & lmask(ll));
    send(PSRP_CMD_WRITE, ad, dd, ll);
  endtask
  task automatic rd(input logic [20:0] ad, input logic [1:0] ll);
    send(PSRP_CMD_READ, ad, 16'h0000, ll);
    expect_word(shadow[ad] & lmask(ll));
  endtask

  // ----------------------------------------------------------------------
  // pin timing watcher, widths in clock cycles
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == TMO) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: run did not finish", $time);
      end_of_test();
    end
    if (!srst) begin
      chk1(!busClash);
      if (memPins.chipEnableN && ceLow > 0) begin
        chk1(ceLow >= (wasRead ? READ_CYC : WR_CYC));
        chk1(ceLow <= MAX_CYC);
      end
      if (!memPins.chipEnableN && ceLow == 0) begin
        chk1(ceHigh >= CEGAP_CYC);
        chk1(selHigh >= SLP);
      end
      if (memPins.writeStrobeN && weLow > 0) chk1(weLow >= WPULSE_CYC);
      if (!memPins.writeStrobeN && weLow == 0) chk1(weHigh >= WEGAP_CYC);
      if (memPins.powerSelect && selLow > 0) chk1(selLow >= SLP);
      // a page step also covers two flops of read-data sync latency
      if (!memPins.chipEnableN && ceLow > 0 && wordAddress != aPrev)
        chk1(aHold >= PAGE_CYC + 2);
    end
    wasRead = memPins.chipEnableN ? 1'b0
      : (wasRead || !memPins.outputEnableN);
    aHold   = (wordAddress != aPrev) ? 1 : aHold + 1;
    aPrev   = wordAddress;
    ceLow   = memPins.chipEnableN ? 0 : ceLow + 1;
    ceHigh  = memPins.chipEnableN ? ceHigh + 1 : 0;
    weLow   = memPins.writeStrobeN ? 0 : weLow + 1;
    weHigh  = memPins.writeStrobeN ? weHigh + 1 : 0;
    selLow  = memPins.powerSelect ? 0 : selLow + 1;
    selHigh = memPins.powerSelect ? selHigh + 1 : 0;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h7f51899c));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    check({15'h0, contentLost}, 16'h0001);
    check({10'h0, memPins}, {10'h0, PINS_IDLE});
    check({15'h0, dataBusOe}, 16'h0000);
    // ends of the address space, every lane mode on each
    wr(21'h000000, 16'h1234, 2'b11);
    wr(21'h1fffff, 16'hbeef, 2'b11);
    wr(21'h1fffff, 16'h00c3, 2'b01);
    for (int k = 1; k < 4; k++) begin
      rd(21'h000000, 2'(k));
      rd(21'h1fffff, 2'(k));
    end
    check({15'h0, contentLost}, 16'h0000);
    $display("TB: corner test done");
    // random full writes, byte merges and byte reads back to back
    for (int i = 0; i < 24; i++) begin
      a = 21'($urandom);
      d = 16'($urandom);
      l = 2'($urandom_range(3, 1));
      wr(a, 16'($urandom), 2'b11);
      wr(a, d, l);
      rd(a, 2'($urandom_range(3, 1)));
    end
    $display("TB: random test done");
    // page burst from an unaligned start returns words from the base
    a = 21'($urandom) & 21'h1ffff8;
    for (int k = 0; k < PAGE_WORDS; k++) wr(a | 21'(k), 16'($urandom), 2'b11);
    send(PSRP_CMD_PAGE, a | 21'h5, 16'h0000, 2'b11);
    for (int k = 0; k < PAGE_WORDS; k++) expect_word(shadow[a | 21'(k)]);
    $display("TB: page test done");
    // power-down loses the contents until rewritten
    send(PSRP_CMD_SLEEP, 21'h000000, 16'h0000, 2'b00);
    shadow.delete();
    wait_ready();
    check({15'h0, contentLost}, 16'h0001);
    wr(a, 16'h9a6e, 2'b11);
    rd(a, 2'b11);
    check({15'h0, contentLost}, 16'h0000);
    $display("TB: power-down test done");
    end_of_test();
  end
endmodule // tb_top
